// File: common/spsa_pkg.sv
package spsa_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_SPEED = 8'h08;
  localparam logic [7:0] REG_TRAVEL = 8'h0C;
  localparam logic [7:0] REG_TRAVEL_CHG = 8'h10;
  localparam logic [7:0] REG_STROKE_HI = 8'h14;
  localparam logic [7:0] REG_STROKE_LO = 8'h18;
  localparam logic [7:0] REG_DECEL = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_FEED = 8'h24;
  localparam logic [7:0] REG_POST_LO = 8'h28;
  localparam logic [7:0] REG_POST_HI = 8'h2C;
  localparam logic [7:0] REG_IRQ_ST = 8'h30;
  localparam logic [7:0] REG_IRQ_MASK = 8'h34;
  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int CTRL_KEEP = 0;
  localparam int CTRL_EN = 1;
  localparam int CTRL_NC = 2;
  localparam int CMD_FWD = 0;
  localparam int CMD_REV = 1;
  localparam int CMD_RESTART = 2;
  localparam int CMD_STOP = 3;
  localparam int ST_START_ACC = 0;
  localparam int ST_SPEED_CTRL = 1;
  localparam int ST_DONE = 2;
  localparam int ST_ERR = 3;
  localparam int ST_CODE_LSB = 16;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_SW = 2;
  localparam logic [15:0] ERR_OVERRUN = 16'h00D1;
  localparam logic [15:0] ERR_STROKE = 16'h00D2;
  localparam logic [31:0] STROKE_HI_RST = 32'h7FFF_FFFF;
  localparam logic [31:0] STROKE_LO_RST = 32'h8000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int OP_CYCLE_NS = 1000000;
  localparam int OP_DIV_DEFAULT = OP_CYCLE_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {PH_IDLE, PH_SPEED, PH_POS, PH_STOP, PH_ABORT, PH_HALT} spsa_phase_e;
endpackage

// File: src/spsa_axis_seq.sv
// Notes on behaviour
// - Switch edge polarity set by contact type
// - Keep off: feed cleared, then updated
// - Keep on: feed kept, then updated
// - Negative travel gives deceleration stop
// - Switch event loads travel-change register
// - Post-switch travel held as two words
// - Switch needs start, speed phase, enable
// - Enabled active switch at start: position only
// - Travel below deceleration distance: decelerate now
// - Overrun: error 209, no completion flag
// - No stroke check in speed; error 210
// - Re-start accepted after stop, either phase
// - Speed-phase re-start switches on later event
// - Position-phase re-start finishes original travel
// - Re-start uses speed latched at start
// - Forward increases address, reverse decreases
// - Enable after active switch: no switch
module spsa_axis_seq
  import spsa_pkg::*;
#(
  parameter int OP_DIV = OP_DIV_DEFAULT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Axis side
  input wire logic switchPin,
  input wire logic [31:0] deviation,
  output logic [15:0] axisSpeed,
  output logic axisDirNeg,
  output logic [31:0] feedValue,
  // Interrupt
  output logic irq
);
  generate
    if (OP_DIV < 2) begin : g_bad_div
      $error("OP_DIV must be at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [2:0] ctrl;
    logic [3:0] cmd;
    logic [15:0] speedSet;
    logic [31:0] travelInd;
    logic [31:0] travelChg;
    logic [31:0] strokeHi;
    logic [31:0] strokeLo;
    logic [3:0] decelShift;
    spsa_phase_e ph;
    logic haltPos;
    logic [15:0] spd;
    logic [15:0] latSpd;
    logic dirNeg;
    logic [31:0] feed;
    logic [31:0] remain;
    logic [31:0] post;
    logic [15:0] errCode;
    logic startAcc;
    logic speedCtrl;
    logic done;
    logic errFlag;
    logic sync1;
    logic sync2;
    logic swPrev;
    logic [2:0] irqSt;
    logic [2:0] irqMask;
    logic irq;
    logic [31:0] divCnt;
    logic awReady;
    logic wReady;
    logic awHeld;
    logic wHeld;
    logic [ADDR_W-1:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;
  } spsa_state_s;

  spsa_state_s s;
  spsa_state_s n;
  logic opEn;
  logic swAct;
  logic swEvt;
  logic startCmd;
  logic goPos;
  logic [31:0] tSel;
  logic [31:0] dd;
  logic [31:0] mv;
  logic [31:0] tgt;
  logic [15:0] step;
  logic [2:0] setIrq;
  logic [2:0] clrIrq;
  logic [31:0] rdVal;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic regMapped(input logic [ADDR_W-1:0] a);
    case (a)
      REG_CTRL, REG_CMD, REG_SPEED, REG_TRAVEL, REG_TRAVEL_CHG, REG_STROKE_HI,
      REG_STROKE_LO, REG_DECEL, REG_STATUS, REG_FEED, REG_POST_LO, REG_POST_HI,
      REG_IRQ_ST, REG_IRQ_MASK: regMapped = 1'b1;
      default: regMapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      o[i*8 +: 8] = st[i] ? d[i*8 +: 8] : o[i*8 +: 8];
    end
    merge = o;
  endfunction

  // Distance to stop from speed v with step 2^sh, plus servo lag
  function automatic logic [31:0] decelDist(input logic [15:0] v, input logic [3:0] sh,
                                            input logic [31:0] dev);
    logic [31:0] sq;
    sq = 32'(v) * 32'(v);
    decelDist = (sq >> (5'(sh) + 5'd1)) + (dev[31] ? 32'(-dev) : dev);
  endfunction

  assign opEn = (s.divCnt == 32'(OP_DIV - 1));
  assign swAct = s.sync2 ^ s.ctrl[CTRL_NC];
  assign swEvt = opEn && swAct && !s.swPrev && s.ctrl[CTRL_EN] && s.startAcc &&
                 (s.ph == PH_SPEED) && !s.cmd[CMD_STOP];
  assign startCmd = s.cmd[CMD_FWD] || s.cmd[CMD_REV];
  assign step = 16'(16'h0001 << s.decelShift);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    goPos = 1'b0;
    tSel = '0;
    dd = '0;
    mv = '0;
    tgt = '0;
    setIrq = '0;
    clrIrq = '0;
    rdVal = '0;
    n.sync1 = switchPin;
    n.sync2 = s.sync1;
    n.divCnt = opEn ? '0 : s.divCnt + 32'd1;
    if (opEn) begin
      n.swPrev = swAct;
      n.cmd = '0;
      case (s.ph)
        PH_IDLE, PH_HALT: begin
          if (startCmd) begin
            n.latSpd = s.speedSet;
            n.dirNeg = !s.cmd[CMD_FWD];
            n.feed = s.ctrl[CTRL_KEEP] ? s.feed : '0;
            n.spd = '0;
            n.post = '0;
            n.done = 1'b0;
            n.errFlag = 1'b0;
            n.errCode = '0;
            n.startAcc = 1'b1;
            n.haltPos = 1'b0;
            if (s.ctrl[CTRL_EN] && swAct) begin
              goPos = 1'b1;
              tSel = s.travelInd;
            end else begin
              n.ph = PH_SPEED;
              n.speedCtrl = 1'b1;
            end
          end else if (s.ph == PH_HALT && s.cmd[CMD_RESTART]) begin
            n.spd = '0;
            n.startAcc = 1'b1;
            n.ph = s.haltPos ? PH_POS : PH_SPEED;
            n.speedCtrl = !s.haltPos;
          end
        end
        PH_SPEED: begin
          if (s.cmd[CMD_STOP]) begin
            n.ph = PH_STOP;
            n.haltPos = 1'b0;
          end else if (swEvt) begin
            goPos = 1'b1;
            tSel = s.travelChg;
            setIrq[IRQ_SW] = 1'b1;
          end else begin
            n.spd = (s.spd + step >= s.latSpd) ? s.latSpd : 16'(s.spd + step);
            mv = 32'(n.spd);
          end
        end
        PH_POS: begin
          if (s.cmd[CMD_STOP]) begin
            n.ph = PH_STOP;
            n.haltPos = 1'b1;
          end else begin
            dd = decelDist(s.spd, s.decelShift, deviation);
            if (s.remain <= dd) begin
              n.spd = (s.spd > step) ? 16'(s.spd - step) : 16'h0001;
            end else begin
              n.spd = (s.spd + step >= s.latSpd) ? s.latSpd : 16'(s.spd + step);
            end
            mv = (32'(n.spd) < s.remain) ? 32'(n.spd) : s.remain;
            n.remain = s.remain - mv;
            n.post = s.post + mv;
            if (n.remain == '0) begin
              n.ph = PH_IDLE;
              n.done = 1'b1;
              n.startAcc = 1'b0;
              n.spd = '0;
              setIrq[IRQ_DONE] = 1'b1;
            end
          end
        end
        PH_STOP, PH_ABORT: begin
          n.spd = (s.spd > step) ? 16'(s.spd - step) : '0;
          mv = 32'(n.spd);
          // Stop ramp out of position phase still eats into the travel
          if (s.ph == PH_STOP && s.haltPos) begin
            mv = (32'(n.spd) < s.remain) ? 32'(n.spd) : s.remain;
            n.remain = s.remain - mv;
            n.post = s.post + mv;
          end
          if (n.spd == '0) begin
            n.ph = (s.ph == PH_STOP) ? PH_HALT : PH_IDLE;
            n.startAcc = 1'b0;
            n.speedCtrl = 1'b0;
          end
        end
        default: n.ph = PH_IDLE;
      endcase
      if (goPos) begin
        n.speedCtrl = 1'b0;
        n.post = '0;
        dd = decelDist(s.spd, s.decelShift, deviation);
        tgt = n.feed + (s.dirNeg && !startCmd || startCmd && !s.cmd[CMD_FWD] ? 32'(-tSel)
                        : tSel);
        if (tSel[31]) begin
          n.ph = PH_ABORT;
        end else if ($signed(tgt) > $signed(s.strokeHi) ||
                     $signed(tgt) < $signed(s.strokeLo)) begin
          n.ph = PH_ABORT;
          n.errFlag = 1'b1;
          n.errCode = ERR_STROKE;
          setIrq[IRQ_ERR] = 1'b1;
        end else if (tSel < dd) begin
          n.ph = PH_ABORT;
          n.errFlag = 1'b1;
          n.errCode = ERR_OVERRUN;
          setIrq[IRQ_ERR] = 1'b1;
        end else begin
          n.ph = PH_POS;
          n.remain = tSel;
        end
      end
      n.feed = n.feed + (n.dirNeg ? 32'(-mv) : mv);
    end

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s.awReady) begin
      n.awAddr = s_axi_awaddr;
      n.awHeld = 1'b1;
    end
    if (s_axi_wvalid && s.wReady) begin
      n.wData = s_axi_wdata;
      n.wStrb = s_axi_wstrb;
      n.wHeld = 1'b1;
    end
    if (s.awHeld && s.wHeld && !s.bValid) begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.bValid = 1'b1;
      n.bResp = regMapped(s.awAddr) ? RESP_OKAY : RESP_DECERR;
      case (s.awAddr)
        REG_CTRL: n.ctrl = 3'(merge(32'(s.ctrl), s.wData, s.wStrb));
        REG_CMD: n.cmd = n.cmd | 4'(merge('0, s.wData, s.wStrb));
        REG_SPEED: n.speedSet = 16'(merge(32'(s.speedSet), s.wData, s.wStrb));
        REG_TRAVEL: n.travelInd = merge(s.travelInd, s.wData, s.wStrb);
        REG_TRAVEL_CHG: n.travelChg = merge(s.travelChg, s.wData, s.wStrb);
        REG_STROKE_HI: n.strokeHi = merge(s.strokeHi, s.wData, s.wStrb);
        REG_STROKE_LO: n.strokeLo = merge(s.strokeLo, s.wData, s.wStrb);
        REG_DECEL: n.decelShift = 4'(merge(32'(s.decelShift), s.wData, s.wStrb));
        REG_IRQ_ST: clrIrq = 3'(merge('0, s.wData, s.wStrb));
        REG_IRQ_MASK: n.irqMask = 3'(merge(32'(s.irqMask), s.wData, s.wStrb));
        default: ;
      endcase
    end
    if (s.bValid && s_axi_bready) begin
      n.bValid = 1'b0;
    end
    n.awReady = !n.awHeld;
    n.wReady = !n.wHeld;

    // Read channel
    case (s_axi_araddr)
      REG_CTRL: rdVal = 32'(s.ctrl);
      REG_SPEED: rdVal = 32'(s.speedSet);
      REG_TRAVEL: rdVal = s.travelInd;
      REG_TRAVEL_CHG: rdVal = s.travelChg;
      REG_STROKE_HI: rdVal = s.strokeHi;
      REG_STROKE_LO: rdVal = s.strokeLo;
      REG_DECEL: rdVal = 32'(s.decelShift);
      REG_STATUS: begin
        rdVal[ST_START_ACC] = s.startAcc;
        rdVal[ST_SPEED_CTRL] = s.speedCtrl;
        rdVal[ST_DONE] = s.done;
        rdVal[ST_ERR] = s.errFlag;
        rdVal[ST_CODE_LSB +: 16] = s.errCode;
      end
      REG_FEED: rdVal = s.feed;
      REG_POST_LO: rdVal = 32'(s.post[15:0]);
      REG_POST_HI: rdVal = 32'(s.post[31:16]);
      REG_IRQ_ST: rdVal = 32'(s.irqSt);
      REG_IRQ_MASK: rdVal = 32'(s.irqMask);
      default: rdVal = '0;
    endcase
    if (s_axi_arvalid && s.arReady) begin
      n.rData = rdVal;
      n.rResp = regMapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      n.rValid = 1'b1;
      n.arReady = 1'b0;
    end else if (s.rValid && s_axi_rready) begin
      n.rValid = 1'b0;
      n.arReady = 1'b1;
    end

    // Sticky events, set wins over clear
    n.irqSt = (s.irqSt & ~clrIrq) | setIrq;
    n.irq = |(n.irqSt & n.irqMask);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.ph <= PH_IDLE;
      s.strokeHi <= STROKE_HI_RST;
      s.strokeLo <= STROKE_LO_RST;
      s.awReady <= 1'b1;
      s.wReady <= 1'b1;
      s.arReady <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready = s.awReady;
  assign s_axi_wready = s.wReady;
  assign s_axi_bvalid = s.bValid;
  assign s_axi_bresp = s.bResp;
  assign s_axi_arready = s.arReady;
  assign s_axi_rvalid = s.rValid;
  assign s_axi_rdata = s.rData;
  assign s_axi_rresp = s.rResp;
  assign axisSpeed = s.spd;
  assign axisDirNeg = s.dirNeg;
  assign feedValue = s.feed;
  assign irq = s.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence haltRestart;
    opEn && s.ph == PH_HALT && s.cmd[CMD_RESTART] && !startCmd;
  endsequence

  switch_phase_a: assert property (swEvt |=> !s.speedCtrl &&
      (s.ph == PH_POS || s.ph == PH_ABORT)) else $error("switch event not taken");
  travel_load_a: assert property (swEvt |=> s.ph != PH_POS ||
      s.remain == $past(s.travelChg)) else $error("travel change not loaded");
  neg_travel_a: assert property (swEvt && s.travelChg[31] |=> s.ph == PH_ABORT)
    else $error("negative travel not stopped");
  direct_pos_a: assert property (opEn && s.ph == PH_IDLE && startCmd &&
      s.ctrl[CTRL_EN] && swAct |=> !s.speedCtrl ##1 !s.speedCtrl)
    else $error("speed flag raised on direct start");
  feed_clear_a: assert property (opEn && s.ph == PH_IDLE && startCmd &&
      !s.ctrl[CTRL_KEEP] |=> s.feed == '0) else $error("feed not cleared");
  feed_keep_a: assert property (opEn && s.ph == PH_IDLE && startCmd &&
      s.ctrl[CTRL_KEEP] |=> s.feed == $past(s.feed)) else $error("feed not kept");
  overrun_done_a: assert property (s.errCode == ERR_OVERRUN |-> !s.done)
    else $error("completion after overrun");
  stroke_entry_a: assert property ($rose(s.errCode == ERR_STROKE) |->
      $past(s.ph) != PH_POS && s.ph == PH_ABORT) else $error("stroke error misplaced");
  late_enable_a: assert property (opEn && s.ph == PH_SPEED && swAct && s.swPrev |=>
      s.ph == PH_SPEED || s.ph == PH_STOP) else $error("switch on stale level");
  restart_resume_a: assert property (haltRestart |=>
      s.latSpd == $past(s.latSpd) && s.ph == ($past(s.haltPos) ? PH_POS : PH_SPEED))
    else $error("re-start resumed wrongly");
  bresp_hold_a: assert property (s.bValid && !s_axi_bready |=> s.bValid)
    else $error("write response dropped");
endmodule // spsa_axis_seq

// File: verif/spsa_servo_model.sv
module spsa_servo_model #(
  parameter int DEV_LAG = 3
) (
  // Clock
  input wire logic core_clk,
  // Bench stimulus
  input wire logic switchOn,
  input wire logic ncMode,
  // Toward the sequencer
  output logic switchPin,
  output logic [31:0] deviation
);
  timeunit 1ns;
  timeprecision 1ns;
  // Closed contact opens on activation
  always_ff @(posedge core_clk) begin
    switchPin <= switchOn ^ ncMode;
  end
  // Small constant servo lag
  assign deviation = 32'(DEV_LAG);
endmodule // spsa_servo_model

// File: verif/tb.sv
module tb
  import spsa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OPD = 8;
  localparam int CEIL = 60000;
  logic core_clk = 0;
  logic rst_n = 0;
  logic [7:0] awAddr = 0;
  logic [7:0] arAddr = 0;
  logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0, swOn = 0, nc = 0;
  logic [31:0] wData = 0;
  logic awReady, wReady, bValid, arReady, rValid, dirNeg, irq, swPin;
  logic [1:0] bResp, rResp, resp;
  logic [31:0] rData, dev, feed, rd, lo;
  logic [31:0] stAcc = 0;
  logic [15:0] spd;
  int failCount = 0, totalChecks = 0, cycles = 0;

  always #50 core_clk = ~core_clk;

  spsa_axis_seq #(.OP_DIV(OPD)) u_spsa_axis_seq (
    .core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .switchPin(swPin), .deviation(dev), .axisSpeed(spd), .axisDirNeg(dirNeg),
    .feedValue(feed), .irq(irq));

  spsa_servo_model u_spsa_servo_model (
    .core_clk(core_clk), .switchOn(swOn), .ncMode(nc), .switchPin(swPin), .deviation(dev));

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while (!bValid);
    resp = bResp;
    bReady <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge core_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arReady) arValid <= 1'b0;
    end while (!rValid);
    rd = rData;
    resp = rResp;
    rReady <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string m);
    axr(a);
    chk(rd, e, m);
  endtask

  task automatic ticks(input int n);
    repeat (n * OPD) @(posedge core_clk);
  endtask

  task automatic waitSt(input int b, input logic v);
    int n;
    n = 0;
    do begin
      axr(REG_STATUS);
      stAcc = stAcc | rd;
      n++;
    end while (rd[b] !== v && n < 400);
    chk(32'(n < 400), 32'h0000_0001, "status wait");
  endtask

  task automatic postChk(input logic [31:0] e);
    axr(REG_POST_LO);
    lo = rd;
    axr(REG_POST_HI);
    chk({rd[15:0], lo[15:0]}, e, "post travel");
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      failCount++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rdChk(REG_STROKE_HI, STROKE_HI_RST, "stroke hi");
    rdChk(REG_STROKE_LO, STROKE_LO_RST, "stroke lo");
    rdChk(REG_STATUS, 32'h0000_0000, "status rst");
    axr(8'h3C);
    chk(32'(resp), 32'(RESP_DECERR), "unmapped rd");
    axw(8'h3C, 32'h0000_0001);
    chk(32'(resp), 32'(RESP_DECERR), "unmapped wr");
    axw(REG_STATUS, 32'hFFFF_FFFF);
    rdChk(REG_STATUS, 32'h0000_0000, "status ro");
    axw(REG_IRQ_MASK, 32'h0000_0007);
    rdChk(REG_IRQ_MASK, 32'h0000_0007, "mask");
    $display("Test registers done");
    axw(REG_CTRL, 32'h0000_0002);
    axw(REG_SPEED, 32'h0000_000A);
    axw(REG_DECEL, 32'h0000_0002);
    axw(REG_TRAVEL_CHG, 32'h0000_00C8);
    axw(REG_CMD, 32'h0000_0001);
    waitSt(ST_SPEED_CTRL, 1'b1);
    chk(32'(dirNeg), 32'h0000_0000, "fwd dir");
    ticks(6);
    swOn <= 1'b1;
    waitSt(ST_DONE, 1'b1);
    rdChk(REG_IRQ_ST, 32'h0000_0005, "irq status");
    chk(32'(irq), 32'h0000_0001, "irq on");
    postChk(32'h0000_00C8);
    axw(REG_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h0000_0000, "irq masked");
    axw(REG_IRQ_MASK, 32'h0000_0007);
    axw(REG_IRQ_ST, 32'h0000_0007);
    swOn <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h0000_0000, "irq cleared");
    $display("Test switch done");
    axw(REG_TRAVEL_CHG, 32'h0000_0190);
    axw(REG_CMD, 32'h0000_0001);
    waitSt(ST_SPEED_CTRL, 1'b1);
    chk(32'($signed(feed) < 40), 32'h0000_0001, "feed cleared");
    ticks(4);
    chk(32'($signed(feed) > 0), 32'h0000_0001, "feed updates");
    swOn <= 1'b1;
    waitSt(ST_SPEED_CTRL, 1'b0);
    ticks(5);
    axw(REG_CMD, 32'h0000_0008);
    ticks(30);
    swOn <= 1'b0;
    axw(REG_CMD, 32'h0000_0004);
    waitSt(ST_DONE, 1'b1);
    postChk(32'h0000_0190);
    axw(REG_IRQ_ST, 32'h0000_0007);
    $display("Test position restart done");
    axw(REG_CTRL, 32'h0000_0001);
    axw(REG_CMD, 32'h0000_0002);
    waitSt(ST_SPEED_CTRL, 1'b1);
    chk(32'(dirNeg), 32'h0000_0001, "rev dir");
    chk(32'($signed(feed) > 300), 32'h0000_0001, "feed kept");
    swOn <= 1'b1;
    ticks(4);
    axw(REG_CTRL, 32'h0000_0003);
    ticks(4);
    axr(REG_STATUS);
    chk(32'(rd[ST_SPEED_CTRL]), 32'h0000_0001, "late enable");
    axw(REG_SPEED, 32'h0000_001E);
    axw(REG_CMD, 32'h0000_0008);
    ticks(30);
    swOn <= 1'b0;
    axw(REG_CMD, 32'h0000_0004);
    waitSt(ST_SPEED_CTRL, 1'b1);
    ticks(12);
    chk(32'(spd), 32'h0000_000A, "restart speed");
    swOn <= 1'b1;
    waitSt(ST_DONE, 1'b1);
    swOn <= 1'b0;
    axw(REG_IRQ_ST, 32'h0000_0007);
    $display("Test speed restart done");
    axw(REG_CTRL, 32'h0000_0002);
    axw(REG_SPEED, 32'h0000_0028);
    axw(REG_TRAVEL_CHG, 32'h0000_0005);
    axw(REG_CMD, 32'h0000_0001);
    waitSt(ST_SPEED_CTRL, 1'b1);
    ticks(14);
    swOn <= 1'b1;
    waitSt(ST_ERR, 1'b1);
    chk(32'(rd[31:16]), 32'(ERR_OVERRUN), "overrun code");
    chk(32'(rd[ST_DONE]), 32'h0000_0000, "no done");
    swOn <= 1'b0;
    ticks(30);
    chk(32'(spd), 32'h0000_0000, "overrun stop");
    $display("Test overrun done");
    axw(REG_STROKE_HI, 32'h0000_0032);
    axw(REG_SPEED, 32'h0000_000A);
    axw(REG_TRAVEL_CHG, 32'h0000_00C8);
    axw(REG_CMD, 32'h0000_0001);
    waitSt(ST_SPEED_CTRL, 1'b1);
    ticks(10);
    axr(REG_STATUS);
    chk(32'(rd[ST_ERR]), 32'h0000_0000, "no stroke check");
    swOn <= 1'b1;
    waitSt(ST_ERR, 1'b1);
    chk(32'(rd[31:16]), 32'(ERR_STROKE), "stroke code");
    swOn <= 1'b0;
    ticks(20);
    axw(REG_STROKE_HI, STROKE_HI_RST);
    $display("Test stroke done");
    axw(REG_TRAVEL, 32'h0000_001E);
    swOn <= 1'b1;
    ticks(2);
    stAcc = 32'h0000_0000;
    axw(REG_CMD, 32'h0000_0001);
    waitSt(ST_DONE, 1'b1);
    chk(32'(stAcc[ST_SPEED_CTRL]), 32'h0000_0000, "no speed phase");
    swOn <= 1'b0;
    $display("Test direct position done");
    nc <= 1'b1;
    ticks(2);
    axw(REG_CTRL, 32'h0000_0006);
    axw(REG_TRAVEL_CHG, 32'hFFFF_FFEC);
    axw(REG_CMD, 32'h0000_0001);
    waitSt(ST_SPEED_CTRL, 1'b1);
    ticks(4);
    swOn <= 1'b1;
    waitSt(ST_SPEED_CTRL, 1'b0);
    ticks(30);
    axr(REG_STATUS);
    chk(32'(rd[ST_DONE]), 32'h0000_0000, "neg no done");
    chk(32'(spd), 32'h0000_0000, "neg stop");
    swOn <= 1'b0;
    $display("Test closed contact done");
    give_verdict();
  end
endmodule // tb
